// ===== tb/dapt_pin_load.sv
`timescale 1ns/10ps
module dapt_pin_load (
    // Pins as driven by the block
    input  wire pin0_i,
    input  wire oe0_i,
    input  wire pin1_i,
    input  wire oe1_i,
    // Pad levels, pulled low when undriven
    output wire lvl0_o,
    output wire lvl1_o
);
    assign lvl0_o = oe0_i ? pin0_i : 1'b0;
    assign lvl1_o = oe1_i ? pin1_i : 1'b0;
endmodule

// ===== tb/dapt_top_assertions.sv
`timescale 1ns/10ps
`include "dapt_regs.vh"
module dapt_top_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pslverr_o,
    input wire        general_io_data_high_i,
    input wire        gpio_out0_i,
    input wire        gpio_oe0_i,
    input wire        gpio_out1_i,
    input wire        gpio_oe1_i,
    input wire        pulse_output_zero_o,
    input wire        pulse_output_zero_oe_o,
    input wire        pulse_output_one_o,
    input wire        pulse_output_one_oe_o
);
    reg  [7:0]  per_ff, on_ff;
    reg  [10:0] calm_ff;
    reg  [9:0]  gap_ff;
    reg         sel_ff, q_ff, g_ff;
    wire        wr = psel_i & penable_i & pwrite_i;
    wire        z  = pulse_output_zero_o;
    wire        ok = calm_ff > 11'd1030 && !general_io_data_high_i;
    // Shadow registers, cycles since last rise, quiet time
    always @(posedge clk_i) begin
        q_ff    <= z;
        g_ff    <= general_io_data_high_i;
        gap_ff  <= z & ~q_ff ? 10'd1 : gap_ff + {9'h0, ~&gap_ff};
        calm_ff <= wr || g_ff != general_io_data_high_i ? 11'd0 : calm_ff + {10'h0, ~&calm_ff};
        if (wr && paddr_i == `DAPT_ADDR_PERIOD0)
            per_ff <= pwdata_i[7:0];
        if (wr && paddr_i == `DAPT_ADDR_ONTIME0)
            on_ff <= pwdata_i[7:0];
        if (wr && paddr_i == `DAPT_ADDR_PINSEL)
            sel_ff <= pwdata_i[`DAPT_PINSEL_OUT1_BIT];
        if (rst_i) begin
            per_ff  <= 8'hff;
            on_ff   <= 8'h00;
            sel_ff  <= 1'b1;
            calm_ff <= 11'h0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rd;
        psel_i && !pwrite_i && (paddr_i == `DAPT_ADDR_PERIOD0 || paddr_i == `DAPT_ADDR_ONTIME0)
            |-> prdata_o == {24'h0, paddr_i[3] ? on_ff : per_ff};
    endproperty
    a_rd: assert property (p_rd) else $error("read back differs");
    property p_bad;
        psel_i && penable_i && paddr_i > 12'h018 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0);
    endproperty
    a_bad: assert property (p_bad) else $error("unmapped access not refused");
    property p_pin0;
        !$past(rst_i) |-> ($past(general_io_data_high_i) ? pulse_output_zero_o == $past(gpio_out0_i)
            && pulse_output_zero_oe_o == $past(gpio_oe0_i) : pulse_output_zero_oe_o);
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin zero function wrong");
    property p_pin1;
        !$past(rst_i) |-> ($past(sel_ff) ? pulse_output_one_o == $past(gpio_out1_i)
            && pulse_output_one_oe_o == $past(gpio_oe1_i) : pulse_output_one_oe_o);
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin one function wrong");
    property p_zero;
        ok && on_ff == 8'h00 |-> !z;
    endproperty
    a_zero: assert property (p_zero) else $error("high with zero on-time");
    property p_full;
        ok && on_ff > per_ff |-> z;
    endproperty
    a_full: assert property (p_full) else $error("full duty broken");
    property p_per;
        $rose(z) && ok |-> gap_ff == {1'b0, per_ff, 1'b0} + 10'd2;
    endproperty
    a_per: assert property (p_per) else $error("period wrong");
    property p_high;
        $fell(z) && ok |-> gap_ff == {1'b0, on_ff, 1'b0};
    endproperty
    a_high: assert property (p_high) else $error("high time wrong");
endmodule
bind dapt_top dapt_top_chk i_chk (.*);

// ===== tb/dual_aux_pwm_timer_bench.sv
`timescale 1ns/10ps
`include "dapt_regs.vh"
module dual_aux_pwm_timer_bench;
    reg         clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err, ok;
    reg         general_io_data_high_i = 1, gpio_out0_i = 0, gpio_oe0_i = 0;
    reg         gpio_out1_i = 0, gpio_oe1_i = 0;
    reg  [11:0] paddr_i = 12'h0;
    reg  [31:0] pwdata_i = 32'h0, rd, m[0:5];
    reg  [3:0]  pstrb_i = 4'hf;
    reg  [39:0] tab[0:3];
    reg  [7:0]  md, p0, p1, c0, c1;
    wire        pready_o, pslverr_o, l0, l1;
    wire        pulse_output_zero_o, pulse_output_zero_oe_o;
    wire        pulse_output_one_o, pulse_output_one_oe_o;
    wire [31:0] prdata_o;
    int         n_mismatch = 0, n_tests = 0, seed = 32'h746a, cyc = 0, i, t0;
    dapt_top i_dut (.*);
    dapt_pin_load i_load (.pin0_i(pulse_output_zero_o), .oe0_i(pulse_output_zero_oe_o),
        .pin1_i(pulse_output_one_o), .oe1_i(pulse_output_one_oe_o), .lvl0_o(l0), .lvl1_o(l1));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, s, e);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        int k;
        @(posedge clk_i);
        psel_i   <= 1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (pready_o !== 1'b1)
            tally_and_finish;
        rd  = prdata_o;
        err = pslverr_o;
        if (w && a < 12'h018)
            m[a[4:2]] = d & (a == `DAPT_ADDR_MODE ? 32'h100 : a == `DAPT_ADDR_PINSEL ? 32'h80 : 32'hff);
        psel_i    <= 0;
        penable_i <= 0;
    endtask
    task wl(input int ch, input lv);
        ok = 0;
        for (int j = 0; j < 1200 && !ok; j++) begin
            @(negedge clk_i);
            ok = (ch ? l1 : l0) === lv;
        end
        chk(ok, 1);
        if (!ok)
            tally_and_finish;
    endtask
    task meas(input int ch, input int p, input int c);
        int t;
        if (c == 0 || c > p) begin
            repeat (4) @(negedge clk_i);
            for (int j = 0; j < 1100; j++) begin
                @(negedge clk_i);
                chk(ch ? l1 : l0, c != 0);
            end
        end else begin
            wl(ch, 0);
            wl(ch, 1);
            t = cyc;
            wl(ch, 0);
            chk(cyc - t, 2 * c);
            wl(ch, 1);
            chk(cyc - t, 2 * (p + 1));
        end
    endtask
    task rdall;
        for (int j = 0; j < 6; j++) begin
            apb(0, 12'(j * 4), 0);
            chk(rd, m[j]);
        end
    endtask
    initial begin
        m = '{32'hff, 32'hff, 32'h0, 32'h0, 32'h0, 32'h80};
        // Offset rows keep the offset below the period
        tab = '{{8'h1, 8'h00, 8'h03, 8'h01, 8'h09}, {8'h1, 8'hff, 8'h07, 8'h64, 8'h03},
                {8'h0, 8'h09, 8'h04, 8'h02, 8'h01}, {8'h0, 8'hff, 8'h00, 8'h00, 8'h00}};
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        rdall;
        apb(1, 12'h01c, 32'h55);
        chk(err, 1);
        apb(0, 12'h01c, 0);
        chk(rd, 0);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            {gpio_out0_i, gpio_oe0_i, gpio_out1_i, gpio_oe1_i} <= 4'($random(seed));
            repeat (2) @(negedge clk_i);
            chk(l0, gpio_oe0_i & gpio_out0_i);
            chk(l1, gpio_oe1_i & gpio_out1_i);
        end
        general_io_data_high_i <= 0;
        apb(1, `DAPT_ADDR_PINSEL, 0);
        for (i = 0; i < 4; i++) begin
            {md, p0, p1, c0, c1} = tab[i];
            if (i == 3)
                c1 = 8'(1 + {$random(seed)} % 255);
            apb(1, `DAPT_ADDR_MODE, {23'h0, md[0], 8'h0});
            apb(1, `DAPT_ADDR_ONTIME0, {24'h0, c0});
            apb(1, `DAPT_ADDR_ONTIME1, {24'h0, c1});
            apb(1, `DAPT_ADDR_PERIOD1, {24'h0, p1});
            apb(1, `DAPT_ADDR_PERIOD0, {24'h0, p0});
            meas(0, p0, c0);
            meas(1, md ? p1 : p0, c1);
            if (!md && c0 && c1) begin
                wl(0, 0);
                wl(0, 1);
                t0 = cyc;
                wl(1, 1);
                chk(cyc - t0, 2 * (p1 + 1));
            end
            repeat (1100) @(negedge clk_i);
        end
        apb(1, `DAPT_ADDR_MODE, 32'h100);
        apb(1, `DAPT_ADDR_ONTIME0, 32'h3);
        apb(1, `DAPT_ADDR_PERIOD0, 32'h14);
        wl(0, 0);
        wl(0, 1);
        t0 = cyc;
        apb(1, `DAPT_ADDR_ONTIME0, 32'h5);
        wl(0, 0);
        chk(cyc - t0, 6);
        apb(1, `DAPT_ADDR_PERIOD0, 32'h14);
        t0 = cyc;
        wl(0, 1);
        chk(cyc - t0 < 5, 1);
        meas(0, 20, 5);
        rdall;
        tally_and_finish;
    end
endmodule

// ===== verilog/dapt_channel.v
`timescale 1ns/10ps
module dapt_channel #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // Timing control
    input  wire         tick_i,
    input  wire         restart_i,
    input  wire         start_i,
    input  wire [W-1:0] on_time_i,
    // Output waveform and cycle marker
    output wire         wave_o,
    output wire         cycle_start_o
);
    reg [W-1:0] latched_on_ff;
    reg [W:0]   high_cnt_ff;
    reg         started_ff;

    // On-time sampled only at a cycle start
    always @(posedge clk_i) begin
        if (rst_i) begin
            latched_on_ff <= {W{1'b0}};
            high_cnt_ff   <= {(W+1){1'b0}};
            started_ff    <= 1'b0;
        end else if (restart_i) begin
            started_ff  <= 1'b0;
            high_cnt_ff <= {(W+1){1'b0}};
        end else if (start_i) begin
            latched_on_ff <= on_time_i;
            high_cnt_ff   <= {1'b0, on_time_i};
            started_ff    <= 1'b1;
        end else if (tick_i && high_cnt_ff != {(W+1){1'b0}}) begin
            high_cnt_ff <= high_cnt_ff - {{W{1'b0}}, 1'b1};
        end
    end

    assign wave_o        = started_ff && (high_cnt_ff != {(W+1){1'b0}});
    assign cycle_start_o = start_i;
endmodule

// ===== verilog/dapt_regs.vh
`ifndef DAPT_REGS_VH
`define DAPT_REGS_VH

// Register byte addresses
`define DAPT_ADDR_PERIOD0    12'h000
`define DAPT_ADDR_PERIOD1    12'h004
`define DAPT_ADDR_ONTIME0    12'h008
`define DAPT_ADDR_ONTIME1    12'h00c
`define DAPT_ADDR_MODE       12'h010
`define DAPT_ADDR_PINSEL     12'h014
`define DAPT_ADDR_STATUS     12'h018

// Field positions
`define DAPT_MODE_INDEP_BIT  8
`define DAPT_PINSEL_OUT1_BIT 7
`define DAPT_GPDATA_OUT0_BIT 1

// Reset values
`define DAPT_PERIOD_RST      8'hff
`define DAPT_ONTIME_RST      8'h00
`define DAPT_MODE_RST        1'b0
`define DAPT_PINSEL_RST      1'b1
`define DAPT_GPSEL_RST       1'b1

// Counters step once every this many clocks
`define DAPT_TICK_DIV        2

`endif

// ===== verilog/dapt_tick_div.v
`timescale 1ns/10ps
module dapt_tick_div #(
    parameter DIV = 2
) (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Restart divider phase
    input  wire restart_i,
    // One-cycle enable
    output wire tick_o
);
    localparam [7:0] LAST = DIV - 1;

    reg [7:0] cnt_ff;
    wire      last = (cnt_ff == LAST);

    always @(posedge clk_i) begin
        if (rst_i || restart_i || last) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    assign tick_o = last & ~restart_i;
endmodule

// ===== verilog/dapt_top.v
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`include "dapt_regs.vh"

// What this block does
// - Mode bit 8 set runs both generators independently.
// - Independent mode: period register zero and one set their own outputs' periods.
// - Counters step every two clocks; period is two times (register plus one).
// - Period registers accept every 8-bit value from zero to all ones.
// - High time is two clocks times on-time register; zero gives none.
// - On-time beyond period holds the output high all cycle.
// - Mode bit clear selects offset mode sharing period register zero.
// - Offset mode high time still comes from each on-time register.
// - Offset mode: output one rises two times (reg one plus one) after zero.
// - On-time writes take effect at the next cycle start.
// - A period register write clears counters and restarts cycles.
// - Reset: offset mode, periods all ones, on-times zero.
// - Full 8-bit duty resolution exists only at period value 255.
// - Output zero pin carries waveform only when general data bit 1 clear.
// - Output one pin carries waveform only when its select bit clear.
module dapt_top #(
    parameter W = 8
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    input  wire [3:0]  pstrb_i,
    output wire        pready_o,
    output reg  [31:0] prdata_o,
    output wire        pslverr_o,
    // Pin function control from the general data register
    input  wire        general_io_data_high_i,
    // General I/O values used when pins are not in pulse function
    input  wire        gpio_out0_i,
    input  wire        gpio_oe0_i,
    input  wire        gpio_out1_i,
    input  wire        gpio_oe1_i,
    // Pins
    output reg         pulse_output_zero_o,
    output reg         pulse_output_zero_oe_o,
    output reg         pulse_output_one_o,
    output reg         pulse_output_one_oe_o
);
    reg [W-1:0] period_reg_zero_ff;
    reg [W-1:0] period_offset_reg_one_ff;
    reg [W-1:0] on_time_reg_zero_ff;
    reg [W-1:0] on_time_reg_one_ff;
    reg         mode_indep_ff;
    reg         pin_function_select_ff;
    reg [W-1:0] cnt0_ff;
    reg [W-1:0] cnt1_ff;
    reg         off_pending_ff;
    reg         first_ff;

    // Next values of the register file
    reg [W-1:0] nxt_period_reg_zero;
    reg [W-1:0] nxt_period_offset_reg_one;
    reg [W-1:0] nxt_on_time_reg_zero;
    reg [W-1:0] nxt_on_time_reg_one;
    reg         nxt_mode_indep;
    reg         nxt_pin_function_select;

    // Next values of the cycle timers
    reg [W-1:0] nxt_cnt0;
    reg [W-1:0] nxt_cnt1;
    reg         nxt_off_pending;
    reg         nxt_first;

    // Next values of the pins
    reg         nxt_pin0;
    reg         nxt_pin0_oe;
    reg         nxt_pin1;
    reg         nxt_pin1_oe;

    wire        wr_en = psel_i & penable_i & pwrite_i;
    wire        rd_en = psel_i & ~pwrite_i;
    wire        tick;
    wire        wave0;
    wire        wave1;

    function addr_ok;
        input [11:0] a;
        begin
            addr_ok = (a <= `DAPT_ADDR_STATUS) && (a[1:0] == 2'b00);
        end
    endfunction

    function hit;
        input [11:0] a;
        input [11:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Timer increment, shared by both cycle counters
    function [W-1:0] count_up;
        input [W-1:0] v;
        begin
            count_up = v + {{(W-1){1'b0}}, 1'b1};
        end
    endfunction

    // Address decode, one select per writable register
    wire        sel_period0 = hit(paddr_i, `DAPT_ADDR_PERIOD0);
    wire        sel_period1 = hit(paddr_i, `DAPT_ADDR_PERIOD1);
    wire        sel_ontime0 = hit(paddr_i, `DAPT_ADDR_ONTIME0);
    wire        sel_ontime1 = hit(paddr_i, `DAPT_ADDR_ONTIME1);
    wire        sel_mode    = hit(paddr_i, `DAPT_ADDR_MODE);
    wire        sel_pinsel  = hit(paddr_i, `DAPT_ADDR_PINSEL);

    // Byte lane qualified writes; lane one carries the mode bit
    wire        lane0_wr    = wr_en & pstrb_i[0];
    wire        lane1_wr    = wr_en & pstrb_i[1];

    // Any period write restarts both generators
    wire restart = wr_en && pstrb_i[0] &&
                   (hit(paddr_i, `DAPT_ADDR_PERIOD0) ||
                    hit(paddr_i, `DAPT_ADDR_PERIOD1));

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok(paddr_i);

    // Register writes; all 8-bit values legal
    always @* begin
        nxt_period_reg_zero       = period_reg_zero_ff;
        nxt_period_offset_reg_one = period_offset_reg_one_ff;
        nxt_on_time_reg_zero      = on_time_reg_zero_ff;
        nxt_on_time_reg_one       = on_time_reg_one_ff;
        nxt_mode_indep            = mode_indep_ff;
        nxt_pin_function_select   = pin_function_select_ff;
        if (lane0_wr && sel_period0) begin
            nxt_period_reg_zero = pwdata_i[W-1:0];
        end
        if (lane0_wr && sel_period1) begin
            nxt_period_offset_reg_one = pwdata_i[W-1:0];
        end
        // On-time taken at once, used by the channel at its next start
        if (lane0_wr && sel_ontime0) begin
            nxt_on_time_reg_zero = pwdata_i[W-1:0];
        end
        if (lane0_wr && sel_ontime1) begin
            nxt_on_time_reg_one = pwdata_i[W-1:0];
        end
        if (lane1_wr && sel_mode) begin
            nxt_mode_indep = pwdata_i[`DAPT_MODE_INDEP_BIT];
        end
        if (lane0_wr && sel_pinsel) begin
            nxt_pin_function_select = pwdata_i[`DAPT_PINSEL_OUT1_BIT];
        end
    end

    // Register file flops
    always @(posedge clk_i) begin
        if (rst_i) begin
            period_reg_zero_ff       <= `DAPT_PERIOD_RST;
            period_offset_reg_one_ff <= `DAPT_PERIOD_RST;
            on_time_reg_zero_ff      <= `DAPT_ONTIME_RST;
            on_time_reg_one_ff       <= `DAPT_ONTIME_RST;
            mode_indep_ff            <= `DAPT_MODE_RST;
            pin_function_select_ff   <= `DAPT_PINSEL_RST;
        end else begin
            period_reg_zero_ff       <= nxt_period_reg_zero;
            period_offset_reg_one_ff <= nxt_period_offset_reg_one;
            on_time_reg_zero_ff      <= nxt_on_time_reg_zero;
            on_time_reg_one_ff       <= nxt_on_time_reg_one;
            mode_indep_ff            <= nxt_mode_indep;
            pin_function_select_ff   <= nxt_pin_function_select;
        end
    end

    // Read mux
    always @* begin
        prdata_o = 32'h0000_0000;
        if (rd_en) begin
            case (paddr_i)
                `DAPT_ADDR_PERIOD0: prdata_o[W-1:0] = period_reg_zero_ff;
                `DAPT_ADDR_PERIOD1: prdata_o[W-1:0] = period_offset_reg_one_ff;
                `DAPT_ADDR_ONTIME0: prdata_o[W-1:0] = on_time_reg_zero_ff;
                `DAPT_ADDR_ONTIME1: prdata_o[W-1:0] = on_time_reg_one_ff;
                `DAPT_ADDR_MODE:    prdata_o[`DAPT_MODE_INDEP_BIT] = mode_indep_ff;
                `DAPT_ADDR_PINSEL:  prdata_o[`DAPT_PINSEL_OUT1_BIT] = pin_function_select_ff;
                `DAPT_ADDR_STATUS:  prdata_o[1:0] = {wave1, wave0};
                default:            prdata_o = 32'h0000_0000;
            endcase
        end
    end

    dapt_tick_div #(
        .DIV       (`DAPT_TICK_DIV)
    ) u_div (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (restart),
        .tick_o    (tick)
    );

    // Cycle boundaries: period is (reg + 1) ticks
    wire end0 = tick && (cnt0_ff == period_reg_zero_ff);
    wire end1 = tick && (cnt1_ff == period_offset_reg_one_ff);
    // First start after a restart waits for a tick, so the first cycle is whole
    wire first_go = first_ff && tick;
    wire start0 = first_go || end0;
    // Offset: delay counted in cnt1 from output zero's start
    wire start1 = mode_indep_ff ? (first_go || end1)
                                : (off_pending_ff && end1);

    // Output zero timer; a start always begins again from zero
    always @* begin
        nxt_first = first_ff && !tick;
        nxt_cnt0  = cnt0_ff;
        if (start0) begin
            nxt_cnt0 = {W{1'b0}};
        end else if (tick) begin
            nxt_cnt0 = count_up(cnt0_ff);
        end
    end

    // Output one timer: own period, or offset from output zero's start
    always @* begin
        nxt_cnt1        = cnt1_ff;
        nxt_off_pending = off_pending_ff;
        if (mode_indep_ff) begin
            nxt_off_pending = 1'b0;
            if (start1) begin
                nxt_cnt1 = {W{1'b0}};
            end else if (tick) begin
                nxt_cnt1 = count_up(cnt1_ff);
            end
        end else begin
            // Shared period; offset relies on reg one below reg zero
            if (start0) begin
                nxt_cnt1        = {W{1'b0}};
                nxt_off_pending = 1'b1;
            end else if (end1) begin
                nxt_off_pending = 1'b0;
            end else if (tick && off_pending_ff) begin
                nxt_cnt1 = count_up(cnt1_ff);
            end
        end
    end

    // Timer flops; a period write clears them at once
    always @(posedge clk_i) begin
        if (rst_i || restart) begin
            cnt0_ff        <= {W{1'b0}};
            cnt1_ff        <= {W{1'b0}};
            off_pending_ff <= 1'b0;
            first_ff       <= 1'b1;
        end else begin
            cnt0_ff        <= nxt_cnt0;
            cnt1_ff        <= nxt_cnt1;
            off_pending_ff <= nxt_off_pending;
            first_ff       <= nxt_first;
        end
    end

    // High time counts on-time ticks; overruns past the period keep it high
    dapt_channel #(
        .W             (W)
    ) u_ch0 (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .tick_i        (tick),
        .restart_i     (restart),
        .start_i       (start0),
        .on_time_i     (on_time_reg_zero_ff),
        .wave_o        (wave0),
        .cycle_start_o ()
    );

    dapt_channel #(
        .W             (W)
    ) u_ch1 (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .tick_i        (tick),
        .restart_i     (restart),
        .start_i       (start1),
        .on_time_i     (on_time_reg_one_ff),
        .wave_o        (wave1),
        .cycle_start_o ()
    );

    // Pin zero: general I/O owns it while the data bit is set
    always @* begin
        if (!general_io_data_high_i) begin
            nxt_pin0    = wave0;
            nxt_pin0_oe = 1'b1;
        end else begin
            nxt_pin0    = gpio_out0_i;
            nxt_pin0_oe = gpio_oe0_i;
        end
    end

    // Pin one: general I/O owns it while its select bit is set
    always @* begin
        if (!pin_function_select_ff) begin
            nxt_pin1    = wave1;
            nxt_pin1_oe = 1'b1;
        end else begin
            nxt_pin1    = gpio_out1_i;
            nxt_pin1_oe = gpio_oe1_i;
        end
    end

    // Registered so the pads never see decode glitches
    always @(posedge clk_i) begin
        if (rst_i) begin
            pulse_output_zero_o    <= 1'b0;
            pulse_output_zero_oe_o <= 1'b0;
            pulse_output_one_o     <= 1'b0;
            pulse_output_one_oe_o  <= 1'b0;
        end else begin
            pulse_output_zero_o    <= nxt_pin0;
            pulse_output_zero_oe_o <= nxt_pin0_oe;
            pulse_output_one_o     <= nxt_pin1;
            pulse_output_one_oe_o  <= nxt_pin1_oe;
        end
    end
endmodule
